// *** msfh_consts.vh ***
// Constants for the motion state and fault handler.
`ifndef MSFH_CONSTS_VH
`define MSFH_CONSTS_VH
`define MSFH_ADDR_CTRL 12'h000
`define MSFH_ADDR_CMD 12'h004
`define MSFH_ADDR_TARGET 12'h008
`define MSFH_ADDR_SECURE 12'h00C
`define MSFH_ADDR_ACTUAL 12'h010
`define MSFH_ADDR_PARAMS 12'h014
`define MSFH_ADDR_STATUS 12'h018
`define MSFH_ADDR_DUAL 12'h01C
`define MSFH_ADDR_CURRENT 12'h020
`define MSFH_CMD_SETPOS 3'h1
`define MSFH_CMD_GOSEC 3'h2
`define MSFH_CMD_DUAL 3'h3
`define MSFH_CMD_SOFT 3'h4
`define MSFH_CMD_HARD 3'h5
`define MSFH_CMD_STATUS1 3'h6
`define MSFH_SECURE_NONE 11'h400
`define MSFH_SETTLE_NS 32'd1000
`define MSFH_CLK_NS 32'd4
`define MSFH_PWM_PERIOD 8'hFF
`endif

// *** msfh_motion_fault.v ***
// Motion state controller with fault handling, coil current sequencing and PWM regulation.
`timescale 1ns/10ps
`include "msfh_consts.vh"
// Overview of operation
// [RULE_01] Fault summary is OR of pump-fail, undervoltage-two, coil-defect, supply-reset flags.
// [RULE_02] Coil defect during motion forces abrupt stop and sets step-loss.
// [RULE_03] Thermal shutdown: stopped goes shutdown, motion goes decelerated stop.
// [RULE_04] Dual move uses own parameter set, copied at start, shape forced one; code forces one only on the second leg.
// [RULE_05] Shape zero applies after dual sequence; code uses the CTRL shape select bit instead. Status reads RAM velocities.
// [RULE_06] Shutdown left only after thermal and hard-stop flags cleared.
// [RULE_07] Flags clear only after status read and with all causes gone.
// [RULE_08] Master should not change acceleration or min velocity during a move.
// [RULE_09] Parameters written during dual sequence apply at next set-target command; code copies only vmin and acc into the dual set.
// [RULE_10] Secure enable is one unless secure position equals 0x400.
// [RULE_11] Stop flag set leaving stop states, cleared first cycle in stopped.
// [RULE_12] Stopped with position mismatch moves to target, lowest priority.
// [RULE_13] Step-loss keeps position commands accepted; cleared only by status read.
// [RULE_14] Motion start switches hold to run with first step ratio.
// [RULE_15] After deceleration hold DC level for settle time, then hold current.
// [RULE_16] PWM compares sensed current with reference from current level and position.
// [RULE_17] Pump failure issues abrupt stop and raises pump-fail flag.
// [RULE_18] Pump failure during motion also sets step-loss.
// [RULE_19] Bridge voltage drop opens all transistors of that bridge.
// [RULE_20] Open coil flagged when duty stays full for one electrical period.
// [RULE_21] Undervoltage two enters undervoltage stop from stopped, moving, decelerating.
// [RULE_22] Shutdown entry sets bridges high impedance and copies actual into target.
// [RULE_23] Leaving shutdown drives bridges at hold current.
module msfh_motion_fault #(
    parameter SETTLE_CYCLES = (`MSFH_SETTLE_NS + `MSFH_CLK_NS - 1) / `MSFH_CLK_NS
)
(
    input wire clk_sys,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire thermalShutdownIn,
    input wire undervoltageLevelTwoIn,
    input wire pumpFailIn,
    input wire logicSupplyResetIn,
    input wire [1:0] bridgeDropIn,
    input wire [7:0] senseCurrentX,
    input wire [7:0] senseCurrentY,
    output reg [1:0] bridgeOpen,
    output reg bridgeHiZ,
    output reg pwmX,
    output reg pwmY,
    output reg stepPulse,
    output reg stepDir
);
    localparam ST_STOPPED = 3'd0;
    localparam ST_MOVE = 3'd1;
    localparam ST_DECEL = 3'd2;
    localparam ST_HARD = 3'd3;
    localparam ST_SOFT = 3'd4;
    localparam ST_SHUT = 3'd5;
    localparam ST_UNDER = 3'd6;
    localparam ST_DUAL = 3'd7;

    // Reference magnitude for a phase: half-wave triangle over the low four position bits.
    function [7:0] phaseRef;
        input [7:0] level;
        input [4:0] ph;
        reg [11:0] prod;
        begin
            prod = level * (ph[3:0] ^ {4{ph[3]}});
            phaseRef = prod[11:4];
        end
    endfunction

    reg [2:0] state_ff;
    reg [10:0] actPos_ff, tagPos_ff, secPos_ff, dualPos_ff;
    reg [7:0] vmin_ff, vmax_ff, acc_ff, irun_ff, ihold_ff;
    reg [7:0] dVmin_ff, dVmax_ff, dAcc_ff;
    reg pendParams_ff, dualSecond_ff;
    reg accel_shape_select_ff, shapeUse_ff;
    reg tsd_ff, uv2_ff, cpFail_ff, elDef_ff, logic_supply_reset_flag_ff, stepLoss_ff, hs_ff, openCoil_ff;
    reg stopFlag_ff, statusRead_ff, running_ff;
    reg [15:0] settle_ff, stepCnt_ff, openCnt_ff;
    reg [7:0] refX_ff, refY_ff;
    reg [7:0] curLevel_ff;
    reg [2:0] nxt_state;
    wire wrEn = psel & penable & pwrite & pready;
    wire rdEn = psel & ~penable & ~pwrite;
    wire [2:0] cmd = (wrEn && paddr == `MSFH_ADDR_CMD) ? pwdata[2:0] : 3'h0;
    // [RULE_01] fault summary
    wire elFaults = cpFail_ff | uv2_ff | elDef_ff | logic_supply_reset_flag_ff;
    // [RULE_10] secure enable
    wire secEn = (secPos_ff != `MSFH_SECURE_NONE);
    wire posDiff = (actPos_ff != tagPos_ff);
    wire inMotion = (state_ff == ST_MOVE) | (state_ff == ST_DECEL) | (state_ff == ST_DUAL);
    wire [7:0] stepRate = dualSecond_ff || state_ff == ST_DUAL ? dVmin_ff : vmin_ff;
    wire stepTick = (stepCnt_ff >= {8'h00, ~stepRate});
    wire remaining = (actPos_ff - tagPos_ff) < 11'd4 || (tagPos_ff - actPos_ff) < 11'd4;

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_STOPPED:
            begin
                // [RULE_21] undervoltage stop
                if (undervoltageLevelTwoIn)
                    nxt_state = ST_UNDER;
                else if (elDef_ff | tsd_ff | thermalShutdownIn)
                    nxt_state = ST_SHUT;
                // [RULE_12] lowest priority
                else if (cmd == `MSFH_CMD_DUAL)
                    nxt_state = ST_DUAL;
                else if (!stopFlag_ff && posDiff && settle_ff == 16'h0000)
                    nxt_state = ST_MOVE;
            end
            ST_MOVE, ST_DECEL, ST_DUAL:
            begin
                // [RULE_02] coil defect stops
                if (elDef_ff | bridgeDropIn != 2'b00 | pumpFailIn | cmd == `MSFH_CMD_HARD)
                    nxt_state = ST_HARD;
                else if (undervoltageLevelTwoIn)
                    nxt_state = (state_ff == ST_DUAL) ? ST_HARD : ST_UNDER;
                // [RULE_03] thermal soft stop
                else if (thermalShutdownIn | cmd == `MSFH_CMD_SOFT)
                    nxt_state = ST_SOFT;
                else if (state_ff == ST_DUAL && !posDiff && dualSecond_ff)
                    nxt_state = ST_STOPPED;
                else if (state_ff != ST_DUAL && !posDiff)
                    nxt_state = ST_STOPPED;
                else if (state_ff == ST_MOVE && remaining)
                    nxt_state = ST_DECEL;
            end
            ST_HARD, ST_SOFT, ST_UNDER:
                nxt_state = ST_STOPPED;
            ST_SHUT:
            begin
                // [RULE_06] shutdown exit
                if (!tsd_ff && !hs_ff && !elFaults)
                    nxt_state = ST_STOPPED;
            end
            default:
                nxt_state = ST_STOPPED;
        endcase
    end

    wire wrMapped = paddr == `MSFH_ADDR_CTRL || paddr == `MSFH_ADDR_TARGET
        || paddr == `MSFH_ADDR_SECURE || paddr == `MSFH_ADDR_DUAL || paddr == `MSFH_ADDR_PARAMS;
    wire wrBad = (paddr == `MSFH_ADDR_CMD) ? (pwdata[2:0] == 3'h0 || &pwdata[2:0]) : !wrMapped;
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            state_ff <= ST_STOPPED;
            actPos_ff <= 11'h000;
            tagPos_ff <= 11'h000;
            secPos_ff <= `MSFH_SECURE_NONE;
            dualPos_ff <= 11'h000;
            vmin_ff <= 8'h10;
            vmax_ff <= 8'h80;
            acc_ff <= 8'h10;
            irun_ff <= 8'hC0;
            ihold_ff <= 8'h40;
            dVmin_ff <= 8'h10;
            dVmax_ff <= 8'h80;
            dAcc_ff <= 8'h10;
            pendParams_ff <= 1'b0;
            dualSecond_ff <= 1'b0;
            accel_shape_select_ff <= 1'b0;
            shapeUse_ff <= 1'b0;
            tsd_ff <= 1'b0;
            uv2_ff <= 1'b0;
            cpFail_ff <= 1'b0;
            elDef_ff <= 1'b0;
            logic_supply_reset_flag_ff <= 1'b1;
            stepLoss_ff <= 1'b0;
            hs_ff <= 1'b0;
            openCoil_ff <= 1'b0;
            stopFlag_ff <= 1'b0;
            statusRead_ff <= 1'b0;
            running_ff <= 1'b0;
            settle_ff <= 16'h0000;
            stepCnt_ff <= 16'h0000;
            openCnt_ff <= 16'h0000;
            refX_ff <= 8'h00;
            refY_ff <= 8'h00;
            curLevel_ff <= 8'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            bridgeOpen <= 2'b00;
            bridgeHiZ <= 1'b0;
            pwmX <= 1'b0;
            pwmY <= 1'b0;
            stepPulse <= 1'b0;
            stepDir <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            pready <= psel & ~penable;
            // The error is decided in the setup cycle so that it stands beside pready.
            pslverr <= psel & ~penable & (pwrite ? wrBad : paddr > `MSFH_ADDR_CURRENT);
            if (wrEn)
            begin
                case (paddr)
                    `MSFH_ADDR_CTRL:
                    begin
                        irun_ff <= pwdata[7:0];
                        ihold_ff <= pwdata[15:8];
                        accel_shape_select_ff <= pwdata[16];
                    end
                    `MSFH_ADDR_TARGET:
                        tagPos_ff <= pwdata[10:0];
                    `MSFH_ADDR_SECURE:
                        secPos_ff <= pwdata[10:0];
                    `MSFH_ADDR_DUAL:
                        dualPos_ff <= pwdata[10:0];
                    `MSFH_ADDR_PARAMS:
                    begin
                        // RAM always updates; dual copy picks up vmin and acc, not vmax, at the next set-target.
                        vmin_ff <= pwdata[7:0];
                        vmax_ff <= pwdata[15:8];
                        acc_ff <= pwdata[23:16];
                        // [RULE_09] deferred apply
                        pendParams_ff <= (state_ff == ST_DUAL);
                    end
                endcase
            end
            // [RULE_13] position commands accepted with step loss
            if (cmd == `MSFH_CMD_SETPOS && state_ff != ST_HARD && state_ff != ST_SOFT
                && state_ff != ST_SHUT && state_ff != ST_DUAL)
            begin
                tagPos_ff <= pwdata[18:8];
                if (pendParams_ff)
                begin
                    dVmin_ff <= vmin_ff;
                    dAcc_ff <= acc_ff;
                    pendParams_ff <= 1'b0;
                end
            end
            if (cmd == `MSFH_CMD_GOSEC && secEn && (state_ff == ST_STOPPED || inMotion))
                tagPos_ff <= secPos_ff;
            // [RULE_04] dual parameter copy
            if (state_ff == ST_STOPPED && nxt_state == ST_DUAL)
            begin
                dVmin_ff <= pwdata[15:8] != 8'h00 ? pwdata[15:8] : vmin_ff;
                dVmax_ff <= pwdata[23:16] != 8'h00 ? pwdata[23:16] : vmax_ff;
                dAcc_ff <= acc_ff;
                tagPos_ff <= dualPos_ff;
                dualSecond_ff <= 1'b0;
            end
            if (state_ff == ST_DUAL && !posDiff && !dualSecond_ff)
            begin
                dualSecond_ff <= 1'b1;
                tagPos_ff <= pwdata[10:0] ^ dualPos_ff;
            end
            // [RULE_05] shape after sequence
            shapeUse_ff <= (state_ff == ST_DUAL && dualSecond_ff) ? 1'b1 : accel_shape_select_ff;
            if (state_ff != ST_DUAL)
                dualSecond_ff <= 1'b0;
            // [RULE_07] clear after status read
            statusRead_ff <= (cmd == `MSFH_CMD_STATUS1);
            if (statusRead_ff)
            begin
                tsd_ff <= thermalShutdownIn;
                uv2_ff <= undervoltageLevelTwoIn;
                cpFail_ff <= pumpFailIn;
                elDef_ff <= bridgeDropIn != 2'b00;
                logic_supply_reset_flag_ff <= logicSupplyResetIn;
                // [RULE_13] step loss clear
                stepLoss_ff <= 1'b0;
                hs_ff <= (bridgeDropIn != 2'b00) | thermalShutdownIn;
                openCoil_ff <= 1'b0;
            end
            if (thermalShutdownIn)
                tsd_ff <= 1'b1;
            if (undervoltageLevelTwoIn)
                uv2_ff <= 1'b1;
            if (logicSupplyResetIn)
                logic_supply_reset_flag_ff <= 1'b1;
            // [RULE_17] pump fail flag
            if (pumpFailIn)
            begin
                cpFail_ff <= 1'b1;
                // [RULE_18] pump fail step loss
                if (inMotion)
                    stepLoss_ff <= 1'b1;
            end
            // [RULE_19] open defective bridge
            if (bridgeDropIn != 2'b00)
            begin
                bridgeOpen <= bridgeOpen | bridgeDropIn;
                elDef_ff <= 1'b1;
                hs_ff <= 1'b1;
                if (inMotion)
                    stepLoss_ff <= 1'b1;
            end
            else if (state_ff == ST_SHUT && nxt_state == ST_STOPPED)
                bridgeOpen <= 2'b00;
            // [RULE_02] step loss on coil defect
            if (elDef_ff && inMotion)
                stepLoss_ff <= 1'b1;
            // [RULE_11] stop flag
            if (state_ff == ST_HARD || state_ff == ST_SOFT)
                stopFlag_ff <= 1'b1;
            else if (state_ff == ST_STOPPED)
                stopFlag_ff <= 1'b0;
            // [RULE_22] shutdown entry
            if (nxt_state == ST_SHUT && state_ff != ST_SHUT)
                tagPos_ff <= actPos_ff;
            if (state_ff == ST_HARD || state_ff == ST_SOFT)
                tagPos_ff <= actPos_ff;
            bridgeHiZ <= (nxt_state == ST_SHUT);
            // Step generation at a rate set by the active minimum velocity.
            stepPulse <= 1'b0;
            if (inMotion && posDiff)
            begin
                stepCnt_ff <= stepTick ? 16'h0000 : stepCnt_ff + 16'h0001;
                if (stepTick)
                begin
                    stepDir <= ~(tagPos_ff[10] ^ actPos_ff[10]) ? tagPos_ff > actPos_ff
                        : tagPos_ff[10];
                    actPos_ff <= (tagPos_ff > actPos_ff) ? actPos_ff + 11'd1 : actPos_ff - 11'd1;
                    stepPulse <= 1'b1;
                end
            end
            else
                stepCnt_ff <= 16'h0000;
            // [RULE_14] hold to run at start
            if (inMotion)
            begin
                curLevel_ff <= irun_ff;
                running_ff <= 1'b1;
            end
            // [RULE_15] settle then hold
            else if (running_ff)
            begin
                running_ff <= 1'b0;
                settle_ff <= SETTLE_CYCLES[15:0];
            end
            else if (settle_ff != 16'h0000)
                settle_ff <= settle_ff - 16'h0001;
            // [RULE_23] hold current after shutdown
            else if (state_ff != ST_SHUT)
                curLevel_ff <= ihold_ff;
            else
                curLevel_ff <= 8'h00;
            if (settle_ff == 16'h0000 || inMotion)
            begin
                refX_ff <= phaseRef(curLevel_ff, inMotion ? tagPos_ff[4:0] ^ 5'h08 : actPos_ff[4:0]);
                refY_ff <= phaseRef(curLevel_ff, actPos_ff[4:0] + 5'h08);
            end
            // [RULE_16] PWM regulation
            pwmX <= ~bridgeHiZ & ~bridgeOpen[0] & (senseCurrentX < refX_ff);
            pwmY <= ~bridgeHiZ & ~bridgeOpen[1] & (senseCurrentY < refY_ff);
            // [RULE_20] open coil detect
            if (inMotion && (senseCurrentX < refX_ff || senseCurrentY < refY_ff))
            begin
                if (openCnt_ff >= {stepRate, 8'h00})
                begin
                    openCoil_ff <= 1'b1;
                    elDef_ff <= 1'b1;
                end
                else
                    openCnt_ff <= openCnt_ff + 16'h0001;
            end
            else
                openCnt_ff <= 16'h0000;
            if (rdEn)
            begin
                case (paddr)
                    `MSFH_ADDR_CTRL:
                        prdata <= {15'h0, accel_shape_select_ff, ihold_ff, irun_ff};
                    `MSFH_ADDR_TARGET:
                        prdata <= {21'h0, tagPos_ff};
                    `MSFH_ADDR_SECURE:
                        prdata <= {20'h0, secEn, secPos_ff};
                    `MSFH_ADDR_ACTUAL:
                        prdata <= {21'h0, actPos_ff};
                    // [RULE_05] RAM velocities
                    `MSFH_ADDR_PARAMS:
                        prdata <= {8'h0, acc_ff, vmax_ff, vmin_ff};
                    `MSFH_ADDR_STATUS:
                        prdata <= {16'h0, shapeUse_ff, state_ff, stopFlag_ff, openCoil_ff,
                            hs_ff, stepLoss_ff, elFaults, logic_supply_reset_flag_ff, elDef_ff, cpFail_ff,
                            uv2_ff, tsd_ff, pendParams_ff, dualSecond_ff};
                    `MSFH_ADDR_DUAL:
                        prdata <= {21'h0, dualPos_ff};
                    `MSFH_ADDR_CURRENT:
                        prdata <= {8'h0, refY_ff, refX_ff, curLevel_ff};
                    default:
                        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // msfh_motion_fault

// *** msfh_props.sv ***
// Port-level assertions for the motion state and fault handler.
`timescale 1ns/10ps
module msfh_props (
    input wire clk_sys,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire stepPulse,
    input wire thermalShutdownIn,
    input wire undervoltageLevelTwoIn,
    input wire pumpFailIn,
    input wire [1:0] bridgeDropIn,
    input wire [1:0] bridgeOpen,
    input wire bridgeHiZ
);
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_step_single: assert property (stepPulse |=> !stepPulse)
        else $error("step pulse longer than one cycle");
    chk_open_bridge_x: assert property ($rose(bridgeDropIn[0]) |-> ##[1:4] bridgeOpen[0])
        else $error("bridge X not opened");
    chk_open_bridge_y: assert property ($rose(bridgeDropIn[1]) |-> ##[1:4] bridgeOpen[1])
        else $error("bridge Y not opened");
    chk_pump_no_step: assert property (pumpFailIn [*4] |-> !stepPulse)
        else $error("stepping with pump failure");
    chk_uv_no_step: assert property (undervoltageLevelTwoIn [*4] |-> !stepPulse)
        else $error("stepping in undervoltage");
    chk_hiz_thermal: assert property (bridgeHiZ && thermalShutdownIn |=> bridgeHiZ)
        else $error("shutdown left while hot");
endmodule // msfh_props

// *** msfh_apb_master.sv ***
// Bus master model that issues register accesses in place of the host controller.
`timescale 1ns/10ps
module msfh_apb_master (
    input wire clk_sys,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    output reg psel,
    output reg penable,
    output reg pwrite,
    output reg [11:0] paddr,
    output reg [31:0] pwdata
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    task xfer(input reg wr, input reg [11:0] a, input reg [31:0] wd,
              output reg [31:0] rd, output reg err);
        begin
            @(posedge clk_sys);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= wd;
            @(posedge clk_sys);
            penable <= 1'b1;
            @(posedge clk_sys);
            while (pready !== 1'b1)
                @(posedge clk_sys);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // Released data is inverted so a stale word can never look valid.
            pwdata <= ~wd;
        end
    endtask
endmodule // msfh_apb_master

// *** motion_state_fault_handler_tb_top.sv ***
// Self-checking bench for the motion state and fault handler.
`timescale 1ns/10ps
`include "msfh_consts.vh"
module motion_state_fault_handler_tb_top;
    reg clk_sys;
    reg rstn;
    wire psel, penable, pwrite, pready, pslverr, bridgeHiZ, pwmX, pwmY, stepPulse, stepDir;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [1:0] bridgeOpen;
    reg thermalShutdownIn, undervoltageLevelTwoIn, pumpFailIn, logicSupplyResetIn;
    reg [1:0] bridgeDropIn;
    reg [7:0] senseCurrentX, senseCurrentY;
    reg [31:0] rd, v, rnd;
    reg err;
    integer seed, fail_count, check_count, cycles, k, n;

    msfh_motion_fault #(.SETTLE_CYCLES(4)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .thermalShutdownIn(thermalShutdownIn), .undervoltageLevelTwoIn(undervoltageLevelTwoIn),
        .pumpFailIn(pumpFailIn), .logicSupplyResetIn(logicSupplyResetIn),
        .bridgeDropIn(bridgeDropIn), .senseCurrentX(senseCurrentX),
        .senseCurrentY(senseCurrentY), .bridgeOpen(bridgeOpen), .bridgeHiZ(bridgeHiZ),
        .pwmX(pwmX), .pwmY(pwmY), .stepPulse(stepPulse), .stepDir(stepDir));
    msfh_apb_master partner_u (.clk_sys(clk_sys), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));

    task finish_test;
        begin
            $display("checks %0d mismatches %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    task cmp(input [31:0] got, input [31:0] exp, input [8*16:1] what);
        begin
            check_count = check_count + 1;
            if (got !== exp)
            begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: %0s got %h exp %h", $time, what, got, exp);
            end
        end
    endtask

    task wr(input [11:0] a, input [31:0] d);
        partner_u.xfer(1'b1, a, d, rd, err);
    endtask

    task rdr(input [11:0] a);
        partner_u.xfer(1'b0, a, 32'h00000000, rd, err);
    endtask

    task cmd(input [2:0] c);
        wr(`MSFH_ADDR_CMD, {29'h00000000, c});
    endtask

    function [31:0] secExp(input [10:0] p);
        secExp = (p != `MSFH_SECURE_NONE) ? 32'h00000800 : 32'h00000000;
    endfunction

    // Index 0 is pump failure, 1 undervoltage, 2 supply reset; the summary bit goes along.
    function [31:0] faultExp(input integer i);
        faultExp = ((i == 0) ? 32'h10 : (i == 1) ? 32'h08 : 32'h40) | 32'h80;
    endfunction

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        rnd = $random(seed);
        senseCurrentX <= rnd[7:0];
        senseCurrentY <= rnd[15:8];
        cycles = cycles + 1;
        if (cycles == 60000)
        begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: run timed out", $time);
            finish_test;
        end
    end

    initial
    begin
        seed = 32'h447F;
        fail_count = 0;
        check_count = 0;
        cycles = 0;
        rstn = 1'b0;
        {thermalShutdownIn, undervoltageLevelTwoIn, pumpFailIn, logicSupplyResetIn} = 4'h0;
        bridgeDropIn = 2'h0;
        senseCurrentX = 8'h00;
        senseCurrentY = 8'h00;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        rdr(`MSFH_ADDR_STATUS);
        cmp(rd & 32'hC0, 32'hC0, "supply flag");
        cmd(`MSFH_CMD_STATUS1);
        rdr(`MSFH_ADDR_STATUS);
        cmp(rd & 32'hF8, 32'h00, "flags cleared");
        rdr(12'h0FC);
        cmp(rd, 32'h0, "unmapped");
        cmp({31'h0, err}, 32'h1, "unmapped err");
        cmd(3'h0);
        cmp({31'h0, err}, 32'h1, "bad command");
        for (k = 0; k < 8; k = k + 1)
        begin
            rnd = $random(seed);
            v = (k == 0) ? 32'h400 : (k == 1) ? 32'h3FF : (k == 2) ? 32'h401 : rnd & 32'h7FF;
            wr(`MSFH_ADDR_SECURE, v);
            rdr(`MSFH_ADDR_SECURE);
            cmp(rd & 32'h800, secExp(v[10:0]), "secure enable");
        end
        for (k = 0; k < 3; k = k + 1)
        begin
            {logicSupplyResetIn, undervoltageLevelTwoIn, pumpFailIn} <= 3'h1 << k;
            repeat (6) @(posedge clk_sys);
            rdr(`MSFH_ADDR_STATUS);
            cmp(rd & 32'hD8, faultExp(k), "fault set");
            if (k == 1)
                cmp(rd & 32'h7000, 32'h6000, "uv state");
            cmd(`MSFH_CMD_STATUS1);
            rdr(`MSFH_ADDR_STATUS);
            cmp(rd & 32'hD8, faultExp(k), "flag kept");
            {logicSupplyResetIn, undervoltageLevelTwoIn, pumpFailIn} <= 3'h0;
            cmd(`MSFH_CMD_STATUS1);
            cmd(`MSFH_CMD_STATUS1);
            rdr(`MSFH_ADDR_STATUS);
            cmp(rd & 32'hD8, 32'h00, "flag cleared");
        end
        thermalShutdownIn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rdr(`MSFH_ADDR_STATUS);
        cmp(rd & 32'h7004, 32'h5004, "shutdown");
        cmp({31'h0, bridgeHiZ}, 32'h1, "hi-z");
        cmp({30'h0, pwmX, pwmY}, 32'h0, "pwm off");
        cmd(`MSFH_CMD_STATUS1);
        rdr(`MSFH_ADDR_STATUS);
        cmp(rd & 32'h7000, 32'h5000, "still shut");
        thermalShutdownIn <= 1'b0;
        cmd(`MSFH_CMD_STATUS1);
        repeat (4) @(posedge clk_sys);
        rdr(`MSFH_ADDR_STATUS);
        cmp(rd & 32'h7004, 32'h0000, "back stopped");
        cmp({31'h0, bridgeHiZ}, 32'h0, "hi-z off");
        rnd = $random(seed);
        v = 32'h20 + (rnd & 32'h3F);
        wr(`MSFH_ADDR_CMD, {13'h0000, v[10:0], 5'h00, `MSFH_CMD_SETPOS});
        n = 0;
        while (stepPulse !== 1'b1 && n < 3000)
        begin
            @(posedge clk_sys);
            n = n + 1;
        end
        cmp({31'h0, stepPulse}, 32'h1, "motion start");
        cmp({31'h0, stepDir}, 32'h1, "step dir");
        bridgeDropIn <= 2'h3;
        repeat (5) @(posedge clk_sys);
        cmp({30'h0, bridgeOpen}, 32'h3, "bridges open");
        rdr(`MSFH_ADDR_STATUS);
        cmp(rd & 32'h120, 32'h120, "step loss");
        bridgeDropIn <= 2'h0;
        cmd(`MSFH_CMD_STATUS1);
        cmd(`MSFH_CMD_STATUS1);
        rdr(`MSFH_ADDR_STATUS);
        cmp(rd & 32'h120, 32'h000, "loss cleared");
        finish_test;
    end
endmodule // motion_state_fault_handler_tb_top

bind msfh_motion_fault msfh_props chk_u (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pready(pready), .stepPulse(stepPulse),
    .thermalShutdownIn(thermalShutdownIn), .undervoltageLevelTwoIn(undervoltageLevelTwoIn),
    .pumpFailIn(pumpFailIn), .bridgeDropIn(bridgeDropIn), .bridgeOpen(bridgeOpen),
    .bridgeHiZ(bridgeHiZ));
